// *** design/fp_regs_pkg.sv ***
// shared constants and types for the floating-point register-set block
`default_nettype none
package fp_regs_pkg;
  // ************************************************************
  // sizes
  // ************************************************************
  localparam int SETS = 32;
  localparam int SYS_SETS = 8;
  localparam int BASIC_REGS = 16;
  localparam int ADV_REGS = 64;
  localparam logic [5:0] STATUS_IDX = 6'h0e;
  localparam logic [5:0] EXC_IDX = 6'h0f;
  localparam int DMA_LEN_W = 6;
  localparam int DMA_CNT_W = 4;
  // ************************************************************
  // instruction word fields (bit 31 is the first bit on the wire)
  // ************************************************************
  localparam int XFER_HI = 31;
  localparam int XFER_LO = 24;
  localparam int KIND_HI = 23;
  localparam int KIND_LO = 20;
  localparam int IDX_HI = 19;
  localparam int IDX_LO = 14;
  localparam logic [7:0] XFER_DMA = 8'hfe;
  localparam logic [7:0] XFER_PROG = 8'hff;
  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [31:0] STATUS_RST = 32'h0000_0000;
  localparam logic [31:0] EXC_RST = 32'h0000_0000;
  localparam logic [DMA_LEN_W-1:0] DMA_LEN_RST = 6'h00;
  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [3:0] {
    K_ARITH, K_RD, K_WR, K_RD_DBL, K_WR_DBL, K_RD_STAT, K_WR_STAT,
    K_RD_EXC, K_WR_EXC, K_RD_LEN, K_WR_LEN, K_BAD
  } kind_t;
  typedef struct packed {
    logic [31:0] instr;
    logic [63:0] data;
  } cmd_t;
  typedef struct packed {
    logic err;
    logic [63:0] data;
  } rsp_t;
  typedef struct packed {
    kind_t kind;
    logic [5:0] idx;
    logic dma;
    logic ok;
  } dec_t;
endpackage : fp_regs_pkg
`default_nettype wire

// *** design/fp_reg_bank.sv ***
// one bank of 32-bit general-purpose registers
`default_nettype none
module fp_reg_bank #(
  parameter int DEPTH = 512,
  parameter int AW = 9
) (
  input wire logic i_clk,
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [31:0] i_wdata,
  input wire logic [AW-1:0] i_raddr,
  output logic [31:0] o_rdata
);
  // contents are not reset; software restores them on a swap
  logic [31:0] mem [DEPTH];

  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  assign o_rdata = mem[i_raddr];
endmodule : fp_reg_bank
`default_nettype wire

// *** design/fp_cmd_decode.sv ***
// decodes a command word into kind, register index and legality
`default_nettype none
module fp_cmd_decode
  import fp_regs_pkg::*;
#(
  parameter bit ADVANCED = 1'b1
) (
  input wire logic [31:0] i_instr,
  output fp_regs_pkg::dec_t o_dec
);
  logic [7:0] xfer;
  logic [5:0] idx;
  logic [3:0] code;
  logic idx_ok;

  assign xfer = i_instr[XFER_HI:XFER_LO];
  assign idx = i_instr[IDX_HI:IDX_LO];
  assign code = i_instr[KIND_HI:KIND_LO];
  assign idx_ok = ADVANCED || idx < 6'(BASIC_REGS);

  always_comb begin
    o_dec.kind = (code < 4'(K_BAD)) ? kind_t'(code) : K_BAD;
    o_dec.idx = idx;
    o_dec.dma = xfer == XFER_DMA;
    o_dec.ok = (xfer == XFER_DMA || xfer == XFER_PROG) && idx_ok; // RULE9
    unique case (o_dec.kind)
      K_RD_DBL, K_WR_DBL: begin
        // pairs addressed by even member; basic ends below status
        if (idx[0] || (!ADVANCED && idx >= STATUS_IDX)) begin // RULE4 RULE8
          o_dec.ok = 1'b0;
        end
      end
      K_RD_STAT, K_WR_STAT, K_RD_EXC, K_WR_EXC: begin
        if (!ADVANCED) begin // RULE7
          o_dec.ok = 1'b0;
        end
      end
      K_BAD: o_dec.ok = 1'b0;
      default: ;
    endcase
  end
endmodule : fp_cmd_decode
`default_nettype wire

// *** design/fp_accel_regsets.sv ***
// register sets, status, exception opcode and dma length of the accelerator
`default_nettype none
// Function
// RULE1: basic: 32 sets of sixteen 32-bit registers
// RULE2: basic: regs 0-13 general, 14 status, 15 exception
// RULE3: exception captures the faulting command's opcode
// RULE4: double uses even-odd pair; basic seven pairs
// RULE5: upper half in even, lower in odd
// RULE6: advanced: 64 registers plus status, exception
// RULE7: advanced status/exception via own commands only
// RULE8: advanced allows thirty-two double registers
// RULE9: byte fe selects dma, ff programmed transfer
// RULE10: dma length in low six bits only
// RULE11: length read waits for outstanding dma
// RULE12: advanced: top eight sets system only
// RULE13: host swaps only sets without pending exception
// RULE14: last opcode kept beside dma length
// RULE15: host prefers advanced, basic, then coprocessor
// RULE16: host reports configuration code at 0xcc
// RULE17: host-chosen set 0-31 takes every command
// RULE18: reset clears status, exception, pending flags
module fp_accel_regsets
  import fp_regs_pkg::*;
#(
  parameter bit ADVANCED = 1'b1
) (
  input wire logic I_SYS_CLK,
  input wire logic I_NRST,
  input wire logic [4:0] I_SET_SEL,
  input wire logic I_SYS_MODE,
  input wire logic I_CMD_VALID,
  input wire fp_regs_pkg::cmd_t I_CMD,
  output logic O_CMD_READY,
  output logic O_RSP_VALID,
  output fp_regs_pkg::rsp_t O_RSP,
  input wire logic I_EXC_VALID,
  input wire logic [31:0] I_EXC_FLAGS,
  output logic O_EXC_PENDING,
  output logic O_DMA_START,
  input wire logic I_DMA_DONE,
  output logic O_DMA_BUSY
);
  import fp_regs_pkg::*;

  // ************************************************************
  // geometry
  // ************************************************************
  localparam int NREG = ADVANCED ? ADV_REGS : BASIC_REGS; // RULE1 RULE6
  localparam int HALF = NREG / 2;
  localparam int DEPTH = SETS * HALF;
  localparam int AW = $clog2(DEPTH);
  localparam logic [4:0] FIRST_SYS = 5'(SETS - SYS_SETS);

  function automatic logic [AW-1:0] bank_addr(input logic [4:0] s,
                                              input logic [5:0] r);
    bank_addr = AW'(s * HALF + r[5:1]);
  endfunction : bank_addr

  // ************************************************************
  // state
  // ************************************************************
  logic [31:0] status_q [SETS];
  logic [31:0] exc_q [SETS];
  logic [SETS-1:0] pend_q;
  logic [DMA_LEN_W-1:0] len_q;
  logic [DMA_CNT_W-1:0] dcnt_q;
  logic [31:0] last_q;
  rsp_t rsp_q;
  logic rspv_q;
  logic start_q;
  logic rd_len_q;

  // ************************************************************
  // decode
  // ************************************************************
  dec_t dec;
  logic [4:0] set;
  logic acc;
  logic res_blk;
  logic good;
  logic sys_idx;
  logic stat_rd;
  logic stat_wr;
  logic exc_rd;
  logic exc_wr;
  logic gpr_wr;
  logic dbl_wr;
  logic len_wait;
  logic cnt_full;
  logic [31:0] even_rd;
  logic [31:0] odd_rd;
  logic even_we;
  logic odd_we;
  logic [31:0] even_wd;

  fp_cmd_decode #(.ADVANCED(ADVANCED)) u_dec (
    .i_instr(I_CMD.instr),
    .o_dec(dec)
  );

  assign set = I_SET_SEL; // RULE17
  // system sets refuse commands outside system mode
  assign res_blk = ADVANCED && set >= FIRST_SYS && !I_SYS_MODE; // RULE12

  // the length read is the host's sync point: hold it off
  assign len_wait = dec.kind == K_RD_LEN && dcnt_q != '0; // RULE11
  assign cnt_full = dec.dma && (&dcnt_q);
  assign O_CMD_READY = !(I_CMD_VALID && (len_wait || cnt_full));
  assign acc = I_CMD_VALID && O_CMD_READY;
  assign good = acc && dec.ok && !res_blk;

  // basic variant keeps status and exception at 14 and 15
  assign sys_idx = !ADVANCED && dec.idx >= STATUS_IDX; // RULE2
  assign stat_rd = dec.kind == K_RD_STAT ||
                   (sys_idx && dec.kind == K_RD && dec.idx == STATUS_IDX);
  assign stat_wr = dec.kind == K_WR_STAT ||
                   (sys_idx && dec.kind == K_WR && dec.idx == STATUS_IDX);
  assign exc_rd = dec.kind == K_RD_EXC ||
                  (sys_idx && dec.kind == K_RD && dec.idx == EXC_IDX);
  assign exc_wr = dec.kind == K_WR_EXC ||
                  (sys_idx && dec.kind == K_WR && dec.idx == EXC_IDX);

  // ************************************************************
  // general-purpose banks, even and odd members side by side
  // ************************************************************
  assign gpr_wr = good && dec.kind == K_WR && !sys_idx;
  assign dbl_wr = good && dec.kind == K_WR_DBL;
  assign even_we = dbl_wr || (gpr_wr && !dec.idx[0]); // RULE4 RULE8
  assign odd_we = dbl_wr || (gpr_wr && dec.idx[0]);
  // high word lands in the even register
  assign even_wd = dbl_wr ? I_CMD.data[63:32] : I_CMD.data[31:0]; // RULE5

  fp_reg_bank #(.DEPTH(DEPTH), .AW(AW)) u_even (
    .i_clk(I_SYS_CLK),
    .i_we(even_we),
    .i_waddr(bank_addr(set, dec.idx)),
    .i_wdata(even_wd),
    .i_raddr(bank_addr(set, dec.idx)),
    .o_rdata(even_rd)
  );

  fp_reg_bank #(.DEPTH(DEPTH), .AW(AW)) u_odd (
    .i_clk(I_SYS_CLK),
    .i_we(odd_we),
    .i_waddr(bank_addr(set, dec.idx)),
    .i_wdata(I_CMD.data[31:0]),
    .i_raddr(bank_addr(set, dec.idx)),
    .o_rdata(odd_rd)
  );

  // ************************************************************
  // status, exception opcode and pending flag per set
  // ************************************************************
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_NRST) begin
      for (int i = 0; i < SETS; i++) begin
        status_q[i] <= STATUS_RST; // RULE18
        exc_q[i] <= EXC_RST;
      end
    end else if (I_EXC_VALID) begin
      // the arithmetic side reports against the last command
      exc_q[set] <= last_q; // RULE3 RULE14
      status_q[set] <= status_q[set] | I_EXC_FLAGS;
    end else if (good && stat_wr) begin
      status_q[set] <= I_CMD.data[31:0]; // RULE7
    end else if (good && exc_wr) begin
      exc_q[set] <= I_CMD.data[31:0];
    end
  end

  // a status write clears the pending flag, a new exception wins
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_NRST) begin
      pend_q <= '0; // RULE18
    end else if (I_EXC_VALID) begin
      pend_q[set] <= 1'b1; // RULE13
    end else if (good && stat_wr) begin
      pend_q[set] <= 1'b0;
    end
  end

  assign O_EXC_PENDING = pend_q[set];

  always_ff @(posedge I_SYS_CLK) begin
    if (!I_NRST) begin
      last_q <= '0;
    end else if (good) begin
      last_q <= I_CMD.instr;
    end
  end

  // ************************************************************
  // dma length and outstanding transfers
  // ************************************************************
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_NRST) begin
      len_q <= DMA_LEN_RST;
    end else if (good && dec.kind == K_WR_LEN) begin
      len_q <= I_CMD.data[DMA_LEN_W-1:0]; // RULE10
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (!I_NRST) begin
      dcnt_q <= '0;
      start_q <= 1'b0;
    end else begin
      start_q <= good && dec.dma; // RULE9
      unique case ({good && dec.dma, I_DMA_DONE && dcnt_q != '0})
        2'b10: dcnt_q <= dcnt_q + 1'b1;
        2'b01: dcnt_q <= dcnt_q - 1'b1;
        default: ;
      endcase
    end
  end

  assign O_DMA_START = start_q;
  assign O_DMA_BUSY = dcnt_q != '0;

  // ************************************************************
  // response
  // ************************************************************
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_NRST) begin
      rspv_q <= 1'b0;
      rsp_q <= '0;
      rd_len_q <= 1'b0;
    end else begin
      rspv_q <= acc;
      rd_len_q <= good && dec.kind == K_RD_LEN;
      rsp_q.err <= acc && !good; // RULE9 RULE12
      rsp_q.data <= '0;
      if (good) begin
        if (stat_rd) begin
          rsp_q.data <= {32'h0000_0000, status_q[set]};
        end else if (exc_rd) begin
          rsp_q.data <= {32'h0000_0000, exc_q[set]};
        end else if (dec.kind == K_RD_LEN) begin
          rsp_q.data <= 64'(len_q); // RULE10
        end else if (dec.kind == K_RD_DBL) begin
          rsp_q.data <= {even_rd, odd_rd}; // RULE5
        end else if (dec.kind == K_RD) begin
          rsp_q.data <= {32'h0000_0000, dec.idx[0] ? odd_rd : even_rd};
        end
      end
    end
  end

  assign O_RSP_VALID = rspv_q;
  assign O_RSP = rsp_q;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_NRST);

  sequence dma_go_s;
    good && dec.dma;
  endsequence

  sequence exc_evt_s;
    I_EXC_VALID;
  endsequence

  xfer_bad_a: assert property ( // RULE9
    acc && I_CMD.instr[XFER_HI:XFER_LO] != XFER_DMA &&
    I_CMD.instr[XFER_HI:XFER_LO] != XFER_PROG |=> O_RSP_VALID && O_RSP.err)
    else $error("bad transfer byte accepted");

  dma_pulse_a: assert property ( // RULE9
    dma_go_s |=> O_DMA_START ##1 !O_DMA_START || $past(good && dec.dma))
    else $error("dma start pulse wrong");

  len_stall_a: assert property ( // RULE11
    I_CMD_VALID && dec.kind == K_RD_LEN && O_DMA_BUSY |-> !O_CMD_READY)
    else $error("length read passed busy dma");

  len_zero_a: assert property ( // RULE10
    O_RSP_VALID && rd_len_q |-> O_RSP.data[63:DMA_LEN_W] == '0)
    else $error("length high bits not zero");

  exc_cap_a: assert property ( // RULE3
    exc_evt_s |=> exc_q[$past(set)] == $past(last_q) &&
    O_EXC_PENDING == (set == $past(set) || pend_q[set]))
    else $error("exception opcode not captured");

  sys_set_a: assert property ( // RULE12
    acc && ADVANCED && set >= FIRST_SYS && !I_SYS_MODE |=> O_RSP.err)
    else $error("system set open to user");

  dbl_odd_a: assert property ( // RULE4
    acc && (dec.kind == K_RD_DBL || dec.kind == K_WR_DBL) && dec.idx[0]
    |=> O_RSP_VALID && O_RSP.err)
    else $error("odd double index accepted");

  rsp_lat_a: assert property ( // RULE17
    acc |=> O_RSP_VALID ##1 (O_RSP_VALID == $past(acc)))
    else $error("response latency wrong");

  rst_clear_a: assert property (disable iff (1'b0) // RULE18
    !I_NRST |=> pend_q == '0 && !O_DMA_BUSY && !O_RSP_VALID)
    else $error("reset left state behind");
endmodule : fp_accel_regsets
`default_nettype wire

// *** verification/dma_partner.sv ***
// dma engine model that finishes the most recently started transfer after a set delay
`default_nettype none
module dma_partner (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_start,
  input wire logic [7:0] i_delay,
  output logic o_done
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************************
  // one transfer in flight; a slow delay exposes stalls
  // ****************************************************
  logic [7:0] left_q;
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      left_q <= 8'h00;
      o_done <= 1'b0;
    end else begin
      o_done <= (left_q == 8'h01);
      if (i_start) begin
        left_q <= i_delay;
      end else if (left_q != 8'h00) begin
        left_q <= left_q - 8'h01;
      end
    end
  end
endmodule : dma_partner
`default_nettype wire

// *** verification/tb.sv ***
// self-checking bench for the register-set block
`default_nettype none
module tb
  import fp_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************************
  // signals and instances
  // ****************************************************
  logic clk, nrst, sys, cmd_v, ready, rsp_v, exc_v, pend;
  logic dstart, ddone, dbusy, started;
  logic [4:0] sel;
  logic [7:0] delay;
  logic [31:0] flags;
  cmd_t cmd;
  rsp_t rsp, got, rsp_b, got_b;
  int n_fail = 0;
  int checks = 0;
  int stalls;
  // configuration byte the host reports; bit 2 marks the advanced part
  localparam logic [7:0] HW_CFG = 8'h04;
  // host picks the advanced variant whenever it is present
  fp_accel_regsets #(.ADVANCED(HW_CFG[2])) dut_u (
    .I_SYS_CLK(clk), .I_NRST(nrst), .I_SET_SEL(sel), .I_SYS_MODE(sys),
    .I_CMD_VALID(cmd_v), .I_CMD(cmd), .O_CMD_READY(ready),
    .O_RSP_VALID(rsp_v), .O_RSP(rsp), .I_EXC_VALID(exc_v),
    .I_EXC_FLAGS(flags), .O_EXC_PENDING(pend), .O_DMA_START(dstart),
    .I_DMA_DONE(ddone), .O_DMA_BUSY(dbusy)
  );
  // basic variant shadows the same commands; only its answers are read
  fp_accel_regsets #(.ADVANCED(1'b0)) dut_b (
    .I_SYS_CLK(clk), .I_NRST(nrst), .I_SET_SEL(sel), .I_SYS_MODE(sys),
    .I_CMD_VALID(cmd_v), .I_CMD(cmd), .O_CMD_READY(),
    .O_RSP_VALID(), .O_RSP(rsp_b), .I_EXC_VALID(exc_v),
    .I_EXC_FLAGS(flags), .O_EXC_PENDING(), .O_DMA_START(),
    .I_DMA_DONE(ddone), .O_DMA_BUSY()
  );
  dma_partner dma_u (
    .i_clk(clk), .i_nrst(nrst), .i_start(dstart), .i_delay(delay),
    .o_done(ddone)
  );
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ****************************************************
  // tasks
  // ****************************************************
  task automatic end_of_test();
    if (n_fail == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input string nm, input logic [64:0] e,
                     input logic [64:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // request held until ready is seen high at a falling edge; the next rising edge takes it
  task automatic run(input logic [7:0] x, input kind_t k,
                     input logic [5:0] i, input logic [63:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cmd_v <= 1'b1;
    cmd <= {x, k, i, 14'h0000, d};
    @(negedge clk);
    while (ready !== 1'b1 && n < 100) begin
      n++;
      @(negedge clk);
    end
    stalls = n;
    if (ready !== 1'b1) begin
      n_fail++;
      end_of_test();
    end
    @(posedge clk);
    cmd_v <= 1'b0;
    @(negedge clk);
    got = rsp;
    got_b = rsp_b;
    started = dstart;
    chk("rsp_valid", 65'h1, {64'h0, rsp_v});
  endtask : run
  // ****************************************************
  // main sequence
  // ****************************************************
  initial begin
    nrst = 1'b0;
    sel = 5'h00;
    sys = 1'b0;
    cmd_v = 1'b0;
    cmd = '0;
    exc_v = 1'b0;
    flags = 32'h0000_0000;
    delay = 8'h02;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    run(XFER_PROG, K_RD_STAT, 6'h00, 64'h0);
    chk("status_rst", 65'h0, got);
    run(XFER_PROG, K_RD_EXC, 6'h00, 64'h0);
    chk("exc_rst", 65'h0, got);
    chk("pend_rst", 65'h0, {64'h0, pend});
    run(XFER_PROG, K_RD_LEN, 6'h00, 64'h0);
    chk("len_rst", 65'h0, got);
    for (int s = 3; s < 6; s += 2) begin
      @(posedge clk);
      sel <= 5'(s);
      run(XFER_PROG, K_WR, 6'h3f, {32'h0, 24'h0, 8'(s)});
    end
    for (int s = 3; s < 6; s += 2) begin
      @(posedge clk);
      sel <= 5'(s);
      run(XFER_PROG, K_RD, 6'h3f, 64'h0);
      chk("set_word", {33'h0, 24'h0, 8'(s)}, got);
    end
    run(XFER_PROG, K_WR_DBL, 6'h3e, 64'h1111_2222_3333_4444);
    run(XFER_PROG, K_RD, 6'h3e, 64'h0);
    chk("dbl_even", {33'h0, 32'h1111_2222}, got);
    run(XFER_PROG, K_RD, 6'h3f, 64'h0);
    chk("dbl_odd", {33'h0, 32'h3333_4444}, got);
    run(XFER_PROG, K_RD_DBL, 6'h3e, 64'h0);
    chk("dbl_rd", {1'b0, 64'h1111_2222_3333_4444}, got);
    run(XFER_PROG, K_RD_DBL, 6'h3d, 64'h0);
    chk("dbl_odd_idx", {1'b1, 64'h0}, got);
    run(XFER_PROG, K_WR, 6'h0e, 64'h77);
    run(XFER_PROG, K_WR_STAT, 6'h00, 64'h5a);
    run(XFER_PROG, K_RD, 6'h0e, 64'h0);
    chk("gpr14", 65'h77, got);
    run(XFER_PROG, K_RD_STAT, 6'h00, 64'h0);
    chk("status_own", 65'h5a, got);
    chk("b_stat_cmd", {1'b1, 64'h0}, got_b);
    run(XFER_PROG, K_RD_DBL, 6'h0e, 64'h0);
    chk("b_dbl_lim", {1'b1, 64'h0}, got_b);
    run(8'h00, K_RD, 6'h00, 64'h0);
    chk("bad_byte", {1'b1, 64'h0}, got);
    run(XFER_PROG, K_WR_LEN, 6'h00, 64'hffff_ffff_ffff_ffff);
    run(XFER_PROG, K_RD_LEN, 6'h00, 64'h0);
    chk("len_bits", 65'h3f, got);
    delay <= 8'h1e;
    run(XFER_DMA, K_WR, 6'h00, 64'h0);
    chk("dma_start", 65'h1, {64'h0, started});
    run(XFER_PROG, K_RD_LEN, 6'h00, 64'h0);
    chk("len_stall", 65'h1, {64'h0, stalls > 0});
    chk("busy_done", 65'h0, {64'h0, dbusy});
    run(XFER_PROG, K_ARITH, 6'h05, 64'h0);
    @(posedge clk);
    exc_v <= 1'b1;
    flags <= 32'h0000_0300;
    @(posedge clk);
    exc_v <= 1'b0;
    @(negedge clk);
    chk("pend_set", 65'h1, {64'h0, pend});
    run(XFER_PROG, K_RD_EXC, 6'h00, 64'h0);
    chk("exc_op", {33'h0, XFER_PROG, K_ARITH, 6'h05, 14'h0}, got);
    run(XFER_PROG, K_RD_STAT, 6'h00, 64'h0);
    chk("status_flags", 65'h35a, got);
    run(XFER_PROG, K_WR_STAT, 6'h00, 64'h0);
    chk("pend_clr", 65'h0, {64'h0, pend});
    // basic variant: index 15 holds the opcode, 14 the status
    run(XFER_PROG, K_RD, 6'h0f, 64'h0);
    chk("b_exc", {33'h0, XFER_PROG, K_ARITH, 6'h05, 14'h0}, got_b);
    run(XFER_PROG, K_RD, 6'h0e, 64'h0);
    chk("b_stat_reg", 65'h377, got_b);
    // reset in mid-run must clear a captured opcode again
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    run(XFER_PROG, K_RD_EXC, 6'h00, 64'h0);
    chk("exc_rerst", 65'h0, got);
    chk("pend_rerst", 65'h0, {64'h0, pend});
    // system sets: write with privilege, then read without and with it
    @(posedge clk);
    sel <= 5'h18;
    sys <= 1'b1;
    run(XFER_PROG, K_WR, 6'h00, 64'h42);
    @(posedge clk);
    sys <= 1'b0;
    run(XFER_PROG, K_RD, 6'h00, 64'h0);
    chk("sys_refuse", {1'b1, 64'h0}, got);
    @(posedge clk);
    sys <= 1'b1;
    run(XFER_PROG, K_RD, 6'h00, 64'h0);
    chk("sys_allow", 65'h42, got);
    end_of_test();
  end
endmodule : tb
`default_nettype wire
